//--- src/low_side_driver_control.sv
// Register bank and protection logic of the two low-side relay drivers
//
// What this block does
// R01: Drivers forced off outside Normal mode
// R02: Decode at 0x0200 blocking, 0x300 non-blocking
// R03: Control bit 7 enables overtemperature interrupt
// R04: Bits 5,4 pick PWM channel per driver
// R05: Bits 3,2 gate driver with selected PWM
// R06: Bits 1,0 switch drivers once unlocked
// R07: Key field bits 3..0; only 0x5 unlocks
// R08: Wrong key keeps both drivers off
// R09: Software writes key after reset and overvoltage
// R10: Status bit 7 overtemperature; forces drivers off
// R11: Status read clears pending overtemperature flag
// R12: Status bits 3,2 report current limitation
// R13: Status bits 1,0 open load, off masked
// R14: PWM off phase shows no open load
// R15: Overvoltage event clears both enable bits
// R16: Software rewrites key, then enables after overvoltage
// R17: Overtemperature latched; irq only when masked in
// R18: Control write re-enables after overtemperature gone
// R19: Registers reset zero; unused bits read zero
`timescale 1ns/1ps
`default_nettype none

module low_side_driver_control
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire low_side_pkg::reg_request_t request_in,
	output logic [7:0] read_data_out,
	output logic read_valid_out,
	input wire logic normal_mode_in,
	input wire logic overtemp_in,
	input wire logic regulator_overvoltage_event_in,
	input wire logic low_side_irq_mask_in,
	input wire logic [1:0] pwm_channel_in,
	input wire low_side_pkg::driver_sense_t sense_one_in,
	input wire low_side_pkg::driver_sense_t sense_two_in,
	output logic driver_one_on_out,
	output logic driver_two_on_out,
	output logic overtemp_flag_out,
	output logic irq_out
);

	logic [7:0] control_reg;
	logic [7:0] control_next;
	logic [3:0] key_reg;
	logic [3:0] key_next;
	logic shutdown_reg;
	logic shutdown_next;
	logic overtemp_flag_reg;
	logic overtemp_flag_next;
	logic overtemp_seen_reg;
	logic overtemp_seen_next;
	logic [7:0] read_data_reg;
	logic [7:0] read_data_next;
	logic read_valid_reg;
	logic read_valid_next;
	logic in_window;
	logic [7:0] offset;
	logic control_write;
	logic key_write;
	logic status_read;
	logic unlocked;
	logic permit;
	logic cl_one;
	logic cl_two;
	logic ol_one;
	logic ol_two;
	logic [7:0] status_value;

	// Address decode inside either global window
	always_comb
	begin
		in_window = (request_in.addr[15:8] == low_side_pkg::BLOCKING_BASE[15:8])
			|| (request_in.addr[15:8] == low_side_pkg::NONBLOCKING_BASE[15:8]); // [R02]
		offset = request_in.addr[7:0];
		control_write = in_window && request_in.write
			&& (offset == low_side_pkg::DRIVER_CONTROL_OFFSET);
		key_write = in_window && request_in.write
			&& (offset == low_side_pkg::CONTROL_UNLOCK_KEY_OFFSET);
		status_read = in_window && request_in.read
			&& (offset == low_side_pkg::DRIVER_STATUS_OFFSET);
	end

	// Drivers may only conduct when every protection allows it
	always_comb
	begin
		unlocked = (key_reg == low_side_pkg::UNLOCK_KEY_VALUE); // [R07] [R08]
		permit = unlocked && normal_mode_in // [R01]
			&& !overtemp_in && !shutdown_reg; // [R10]
	end

	// Next values of control state, key, shutdown latch and flag
	always_comb
	begin
		control_next = control_reg;
		key_next = key_reg;
		shutdown_next = shutdown_reg;
		if (control_write)
		begin
			control_next = request_in.wdata
				& low_side_pkg::DRIVER_CONTROL_WRITE_MASK; // [R19]
		end
		if (key_write)
		begin
			key_next = request_in.wdata[3:0]; // [R07]
		end
		// Overvoltage wins over a write in the same cycle
		if (regulator_overvoltage_event_in)
		begin
			control_next = control_next
				& ~low_side_pkg::DRIVER_ENABLE_MASK; // [R15]
			key_next = low_side_pkg::UNLOCK_KEY_RESET; // [R09]
		end
		// Shutdown holds until a control write with overtemp gone
		if (overtemp_in)
		begin
			shutdown_next = 1'b1;
		end
		else if (control_write)
		begin
			shutdown_next = 1'b0; // [R18]
		end
		// New overtemperature event latches the flag; set beats clear
		overtemp_seen_next = overtemp_in;
		overtemp_flag_next = overtemp_flag_reg && !status_read; // [R11]
		if (overtemp_in && !overtemp_seen_reg
			&& control_reg[low_side_pkg::OVERTEMP_IRQ_ENABLE_BIT])
		begin
			overtemp_flag_next = 1'b1; // [R03] [R17]
		end
	end

	// Control state registers
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			control_reg <= low_side_pkg::DRIVER_CONTROL_RESET; // [R19]
			key_reg <= low_side_pkg::UNLOCK_KEY_RESET;
			shutdown_reg <= 1'b0;
			overtemp_flag_reg <= 1'b0;
			overtemp_seen_reg <= 1'b0;
		end
		else
		begin
			control_reg <= control_next;
			key_reg <= key_next;
			shutdown_reg <= shutdown_next;
			overtemp_flag_reg <= overtemp_flag_next;
			overtemp_seen_reg <= overtemp_seen_next;
		end
	end

	// Driver one output stage
	driver_output_stage u_driver_one
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.enable_in(control_reg[low_side_pkg::DRIVER_ONE_ENABLE_BIT]), // [R06]
		.permit_in(permit),
		.pwm_gate_in(control_reg[low_side_pkg::PWM_GATE_ENABLE_1_BIT]),
		.pwm_select_in(control_reg[low_side_pkg::PWM_SOURCE_SELECT_1_BIT]),
		.pwm_channel_in(pwm_channel_in),
		.sense_in(sense_one_in),
		.on_out(driver_one_on_out),
		.current_limit_out(cl_one),
		.open_load_out(ol_one)
	);

	// Driver two output stage
	driver_output_stage u_driver_two
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.enable_in(control_reg[low_side_pkg::DRIVER_TWO_ENABLE_BIT]), // [R06]
		.permit_in(permit),
		.pwm_gate_in(control_reg[low_side_pkg::PWM_GATE_ENABLE_2_BIT]),
		.pwm_select_in(control_reg[low_side_pkg::PWM_SOURCE_SELECT_2_BIT]),
		.pwm_channel_in(pwm_channel_in),
		.sense_in(sense_two_in),
		.on_out(driver_two_on_out),
		.current_limit_out(cl_two),
		.open_load_out(ol_two)
	);

	// Status image and read data; unmapped offsets read zero
	always_comb
	begin
		status_value = 8'h00;
		status_value[low_side_pkg::OVERTEMP_PRESENT_BIT] = overtemp_in; // [R10]
		status_value[low_side_pkg::CURRENT_LIMIT_TWO_BIT] = cl_two; // [R12]
		status_value[low_side_pkg::CURRENT_LIMIT_ONE_BIT] = cl_one;
		status_value[low_side_pkg::OPEN_LOAD_TWO_BIT] = ol_two; // [R13]
		status_value[low_side_pkg::OPEN_LOAD_ONE_BIT] = ol_one;
		read_valid_next = in_window && request_in.read;
		read_data_next = read_data_reg;
		if (read_valid_next)
		begin
			unique case (offset)
				low_side_pkg::DRIVER_CONTROL_OFFSET: read_data_next = control_reg;
				low_side_pkg::DRIVER_STATUS_OFFSET: read_data_next = status_value;
				low_side_pkg::CONTROL_UNLOCK_KEY_OFFSET:
					read_data_next = {4'h0, key_reg}; // [R19]
				default: read_data_next = 8'h00;
			endcase
		end
	end

	// Read answer registers
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			read_data_reg <= low_side_pkg::READ_DATA_RESET;
			read_valid_reg <= 1'b0;
		end
		else
		begin
			read_data_reg <= read_data_next;
			read_valid_reg <= read_valid_next;
		end
	end

	assign read_data_out = read_data_reg;
	assign read_valid_out = read_valid_reg;
	assign overtemp_flag_out = overtemp_flag_reg;
	assign irq_out = overtemp_flag_reg && low_side_irq_mask_in; // [R17]

	// Checks on driver outputs and register effects
	property p_mode_off;
		@(posedge clk_in) disable iff (!rst_n_in)
		!normal_mode_in |=> !driver_one_on_out && !driver_two_on_out;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("driver on outside normal mode"); // [R01]

	property p_key_lock;
		@(posedge clk_in) disable iff (!rst_n_in)
		(key_reg != low_side_pkg::UNLOCK_KEY_VALUE)
			|=> !driver_one_on_out && !driver_two_on_out;
	endproperty
	a_key_lock: assert property (p_key_lock) else $error("driver on while locked"); // [R08]

	property p_overtemp_off;
		@(posedge clk_in) disable iff (!rst_n_in)
		overtemp_in |=> !driver_one_on_out && !driver_two_on_out;
	endproperty
	a_overtemp_off: assert property (p_overtemp_off) else $error("driver on in overtemp"); // [R10]

	property p_ov_clear;
		@(posedge clk_in) disable iff (!rst_n_in)
		regulator_overvoltage_event_in |=> (control_reg[1:0] == 2'b00)
			&& (key_reg == low_side_pkg::UNLOCK_KEY_RESET);
	endproperty
	a_ov_clear: assert property (p_ov_clear) else $error("enables kept after overvoltage"); // [R15]

	property p_read_clears;
		@(posedge clk_in) disable iff (!rst_n_in)
		status_read && !overtemp_in |=> !overtemp_flag_out;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("flag survived status read"); // [R11]

	property p_irq_mask;
		@(posedge clk_in) disable iff (!rst_n_in)
		irq_out |-> overtemp_flag_out && low_side_irq_mask_in;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq without mask"); // [R17]

	// Flag may only rise after an overtemperature with the enable set
	property p_flag_src;
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(overtemp_flag_out) |-> $past(overtemp_in)
			&& $past(control_reg[low_side_pkg::OVERTEMP_IRQ_ENABLE_BIT]);
	endproperty
	a_flag_src: assert property (p_flag_src) else $error("flag unarmed"); // [R03]

	property p_ol_off;
		@(posedge clk_in) disable iff (!rst_n_in)
		(ol_one || ol_two) |-> (!ol_one || driver_one_on_out)
			&& (!ol_two || driver_two_on_out);
	endproperty
	a_ol_off: assert property (p_ol_off) else $error("open load while off"); // [R13]

	property p_reserved_zero;
		@(posedge clk_in) disable iff (!rst_n_in)
		read_valid_out |-> ($past(offset) != low_side_pkg::CONTROL_UNLOCK_KEY_OFFSET)
			|| (read_data_out[7:4] == 4'h0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // [R19]

	property p_shutdown_hold;
		@(posedge clk_in) disable iff (!rst_n_in)
		$fell(overtemp_in) && !control_write |=> shutdown_reg;
	endproperty
	a_shutdown_hold: assert property (p_shutdown_hold) else $error("shutdown released early"); // [R18]

	c_driver_on: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		driver_one_on_out ##1 driver_two_on_out);
	c_overtemp_irq: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		irq_out ##1 status_read);
	c_ov_event: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		driver_one_on_out ##1 regulator_overvoltage_event_in);

endmodule

`default_nettype wire

//--- common/low_side_pkg.sv
// Constants and carrier types for the low-side driver control block
`default_nettype none

package low_side_pkg;

	// Global windows of the die-to-die register space
	localparam logic [15:0] BLOCKING_BASE = 16'h0200;
	localparam logic [15:0] NONBLOCKING_BASE = 16'h0300;

	// Register offsets inside a window
	localparam logic [7:0] DRIVER_CONTROL_OFFSET = 8'h30;
	localparam logic [7:0] DRIVER_STATUS_OFFSET = 8'h31;
	localparam logic [7:0] CONTROL_UNLOCK_KEY_OFFSET = 8'h32;

	// Values after reset
	localparam logic [7:0] DRIVER_CONTROL_RESET = 8'h00;
	localparam logic [3:0] UNLOCK_KEY_RESET = 4'h0;
	localparam logic [7:0] READ_DATA_RESET = 8'h00;

	// Control register field positions
	localparam int OVERTEMP_IRQ_ENABLE_BIT = 7;
	localparam int PWM_SOURCE_SELECT_2_BIT = 5;
	localparam int PWM_SOURCE_SELECT_1_BIT = 4;
	localparam int PWM_GATE_ENABLE_2_BIT = 3;
	localparam int PWM_GATE_ENABLE_1_BIT = 2;
	localparam int DRIVER_TWO_ENABLE_BIT = 1;
	localparam int DRIVER_ONE_ENABLE_BIT = 0;

	// Writable bits of the control register; bit 6 is reserved
	localparam logic [7:0] DRIVER_CONTROL_WRITE_MASK = 8'hBF;
	// Both driver enable bits
	localparam logic [7:0] DRIVER_ENABLE_MASK = 8'h03;

	// Status register field positions
	localparam int OVERTEMP_PRESENT_BIT = 7;
	localparam int CURRENT_LIMIT_TWO_BIT = 3;
	localparam int CURRENT_LIMIT_ONE_BIT = 2;
	localparam int OPEN_LOAD_TWO_BIT = 1;
	localparam int OPEN_LOAD_ONE_BIT = 0;

	// The only key value that unlocks driver control
	localparam logic [3:0] UNLOCK_KEY_VALUE = 4'h5;

	// One register access from the die-to-die interface
	typedef struct packed {
		logic [15:0] addr;
		logic write;
		logic read;
		logic [7:0] wdata;
	} reg_request_t;

	// Analog feedback of one driver
	typedef struct packed {
		logic current_limit;
		logic open_load;
	} driver_sense_t;

endpackage

`default_nettype wire

//--- src/driver_output_stage.sv
// One low-side driver: PWM source pick, gating and open-load masking
`timescale 1ns/1ps
`default_nettype none

module driver_output_stage
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic enable_in,
	input wire logic permit_in,
	input wire logic pwm_gate_in,
	input wire logic pwm_select_in,
	input wire logic [1:0] pwm_channel_in,
	input wire low_side_pkg::driver_sense_t sense_in,
	output logic on_out,
	output logic current_limit_out,
	output logic open_load_out
);

	logic on_reg;
	logic on_next;
	logic current_limit_reg;
	logic current_limit_next;
	logic open_load_reg;
	logic open_load_next;
	logic pwm_level;

	// Next output state and masked status
	always_comb
	begin
		pwm_level = pwm_channel_in[pwm_select_in]; // [R04]
		on_next = enable_in && permit_in && (!pwm_gate_in || pwm_level); // [R05]
		current_limit_next = sense_in.current_limit; // [R12]
		// Follows next gate state, so never shown while off or PWM low
		open_load_next = sense_in.open_load && on_next; // [R13] [R14]
	end

	// Registered driver output and status
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			on_reg <= 1'b0;
			current_limit_reg <= 1'b0;
			open_load_reg <= 1'b0;
		end
		else
		begin
			on_reg <= on_next;
			current_limit_reg <= current_limit_next;
			open_load_reg <= open_load_next;
		end
	end

	assign on_out = on_reg;
	assign current_limit_out = current_limit_reg;
	assign open_load_out = open_load_reg;

endmodule

`default_nettype wire

//--- tb/mcu_bus_model.sv
// Microcontroller side of the die-to-die register access, as a bus model
`timescale 1ns/1ps
`default_nettype none

module mcu_bus_model
(
	input wire logic clk_in,
	input wire logic [7:0] read_data_in,
	input wire logic read_valid_in,
	output low_side_pkg::reg_request_t request_out
);
	// Bus starts idle with both strobes low
	initial request_out = '0;

	// Releasing drives inverted lines so a stale value is never mistaken
	task automatic release_bus();
		request_out = '{addr: ~request_out.addr, write: 1'b0, read: 1'b0,
			wdata: ~request_out.wdata};
	endtask

	// One write cycle, held across the taking edge
	task automatic write_reg(input logic [15:0] addr, input logic [7:0] data);
		@(posedge clk_in);
		#1;
		request_out = '{addr: addr, write: 1'b1, read: 1'b0, wdata: data};
		@(posedge clk_in);
		#1;
		release_bus();
	endtask

	// One read cycle; answer is taken the cycle after the request
	task automatic read_reg(input logic [15:0] addr, output logic [7:0] data,
		output logic valid);
		@(posedge clk_in);
		#1;
		request_out = '{addr: addr, write: 1'b0, read: 1'b1, wdata: 8'h00};
		@(posedge clk_in);
		#1;
		valid = read_valid_in;
		data = read_data_in;
		release_bus();
	endtask
endmodule
`default_nettype wire

//--- tb/test_low_side_driver_control.sv
// Self-checking testbench of the low-side driver control block
`timescale 1ns/1ps
`default_nettype none

module test_low_side_driver_control;
	localparam logic [15:0] A_CTL = 16'h0230;
	localparam logic [15:0] A_STS = 16'h0231;
	localparam logic [15:0] A_KEY = 16'h0232;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic normal_mode = 1'b1;
	logic overtemp = 1'b0;
	logic overvolt = 1'b0;
	logic irq_mask = 1'b0;
	logic [1:0] pwm = 2'b00;
	low_side_pkg::driver_sense_t sense_one = '0;
	low_side_pkg::driver_sense_t sense_two = '0;
	low_side_pkg::reg_request_t request;
	logic [7:0] read_data;
	logic read_valid;
	logic drv_one;
	logic drv_two;
	logic ot_flag;
	logic irq;
	int err_count = 0;
	int n_checks = 0;

	// 125 MHz clock
	always #4 clk_in = ~clk_in;

	mcu_bus_model mcu_u
	(
		.clk_in(clk_in),
		.read_data_in(read_data),
		.read_valid_in(read_valid),
		.request_out(request)
	);

	low_side_driver_control dut_u
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.request_in(request),
		.read_data_out(read_data),
		.read_valid_out(read_valid),
		.normal_mode_in(normal_mode),
		.overtemp_in(overtemp),
		.regulator_overvoltage_event_in(overvolt),
		.low_side_irq_mask_in(irq_mask),
		.pwm_channel_in(pwm),
		.sense_one_in(sense_one),
		.sense_two_in(sense_two),
		.driver_one_on_out(drv_one),
		.driver_two_on_out(drv_two),
		.overtemp_flag_out(ot_flag),
		.irq_out(irq)
	);

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Read one register and expect an answer with the given data
	task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		mcu_u.read_reg(addr, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask

	// Let registered driver outputs follow their causes
	task automatic settle();
		repeat (2) @(posedge clk_in);
		#1;
	endtask

	// Check both driver gates at once
	task automatic drv(input logic [1:0] exp);
		chk({6'h00, drv_two, drv_one}, {6'h00, exp});
	endtask

	// Print counts and verdict, then stop
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial
	begin
		#100000;
		err_count++;
		test_done();
	end

	// Main sequence
	initial
	begin
		logic [7:0] d;
		logic v;
		repeat (12) @(posedge clk_in);
		#1;
		rst_n_in = 1'b1;
		rd(A_CTL, 8'h00);
		rd(A_STS, 8'h00);
		rd(A_KEY, 8'h00);
		mcu_u.write_reg(A_CTL, 8'h03);
		settle();
		drv(2'b00);
		mcu_u.write_reg(A_KEY, 8'h06);
		settle();
		drv(2'b00);
		mcu_u.write_reg(A_KEY, 8'hF5);
		rd(A_KEY, 8'h05);
		settle();
		drv(2'b11);
		mcu_u.write_reg(A_CTL, 8'hFF);
		rd(A_CTL, 8'hBF);
		mcu_u.write_reg(A_STS, 8'hFF);
		rd(A_STS, 8'h00);
		// Driver two on channel 1, driver one on channel 0
		mcu_u.write_reg(A_CTL, 8'h2F);
		pwm = 2'b01;
		settle();
		drv(2'b01);
		pwm = 2'b10;
		sense_one = '{current_limit: 1'b0, open_load: 1'b1};
		sense_two = '{current_limit: 1'b1, open_load: 1'b0};
		settle();
		drv(2'b10);
		rd(A_STS, 8'h08);
		pwm = 2'b01;
		settle();
		rd(A_STS, 8'h09);
		rd(16'h0330, 8'h2F);
		mcu_u.read_reg(16'h0130, d, v);
		chk({7'h00, v}, 8'h00);
		sense_one = '0;
		sense_two = '0;
		mcu_u.write_reg(A_CTL, 8'h03);
		normal_mode = 1'b0;
		settle();
		drv(2'b00);
		normal_mode = 1'b1;
		// Overtemperature with interrupt enabled
		mcu_u.write_reg(A_CTL, 8'h83);
		irq_mask = 1'b1;
		overtemp = 1'b1;
		settle();
		drv(2'b00);
		chk({6'h00, ot_flag, irq}, 8'h03);
		irq_mask = 1'b0;
		#1;
		chk({7'h00, irq}, 8'h00);
		rd(A_STS, 8'h80);
		chk({7'h00, ot_flag}, 8'h00);
		overtemp = 1'b0;
		settle();
		drv(2'b00);
		mcu_u.write_reg(A_CTL, 8'h03);
		settle();
		drv(2'b11);
		overtemp = 1'b1;
		settle();
		chk({7'h00, ot_flag}, 8'h00);
		overtemp = 1'b0;
		mcu_u.write_reg(A_CTL, 8'h03);
		// Regulator overvoltage pulse
		@(posedge clk_in);
		#1;
		overvolt = 1'b1;
		@(posedge clk_in);
		#1;
		overvolt = 1'b0;
		settle();
		drv(2'b00);
		rd(A_CTL, 8'h00);
		mcu_u.write_reg(A_CTL, 8'h03);
		settle();
		drv(2'b00);
		mcu_u.write_reg(A_KEY, 8'h05);
		mcu_u.write_reg(A_CTL, 8'h03);
		settle();
		drv(2'b11);
		test_done();
	end
endmodule
`default_nettype wire
